/* File: verilog/interrupt_state_signaling.v */
// Purpose: Per-source interrupt lifecycle and request signalling
// Assumes: Single clock, all inputs synchronous, one processing element
// Notes:   Sources 0..63 held; shared ids above 63 are accepted but dropped
`default_nettype none
`include "irq_state_regs.vh"

module interrupt_state_signaling (
	input  wire                            clk,
	input  wire                            rst_n,
	input  wire [`NUM_SHARED-1:0]          shared_irq_wire,
	input  wire [`NUM_PRIV-1:0]            private_irq_wire,
	input  wire                            shared_set_wr,
	input  wire                            shared_clear_wr,
	input  wire [`ID_W-1:0]                shared_msg_id,
	input  wire                            loc_msg_wr,
	input  wire [`LOC_ID_W-1:0]            loc_msg_id,
	input  wire                            soft_wr,
	input  wire [`ID_W-1:0]                soft_id,
	input  wire [`NUM_SRC-1:0]             src_enable,
	input  wire [`NUM_SRC-1:0]             src_edge,
	input  wire [`NUM_SRC-1:0]             src_prio_ok,
	input  wire [`NUM_SRC*`GRP_W-1:0]      src_group,
	input  wire [`AFF_W-1:0]               shared_target_aff,
	input  wire [`AFF_W-1:0]               core_affinity_id_reg,
	input  wire                            core_secure,
	input  wire                            core_top_level,
	input  wire                            ack_rd,
	input  wire                            eoi_wr,
	input  wire [`ID_W-1:0]                eoi_id,
	output reg                             irq_normal,
	output reg                             irq_fast,
	output reg                             ack_valid,
	output reg  [`ID_W-1:0]                ack_id,
	output reg  [`NUM_SRC*2-1:0]           src_state,
	output reg                             loc_msg_valid,
	output reg  [`LOC_ID_W-1:0]            loc_msg_id_out,
	output reg                             top_affinity_level_support_flag
);

	reg  [`NUM_SRC-1:0]    pend;
	reg  [`NUM_SRC-1:0]    act;
	reg  [`NUM_SRC-1:0]    line_q;
	reg  [`NUM_SHARED-1:0] shared_msg_level;
	reg  [`NUM_SRC-1:0]    next_pend;
	reg  [`NUM_SRC-1:0]    next_act;
	reg  [`NUM_SRC-1:0]    line;
	reg  [`NUM_SRC-1:0]    req;
	reg  [`NUM_SRC-1:0]    fast_sel;
	reg  [`NUM_SHARED-1:0] next_msg_level;
	reg  [`ID_W-1:0]       pick_id;
	reg                    pick_ok;
	reg                    targeted;
	reg                    ack_take;
	reg                    eoi_hit;
	integer                i;
	integer                j;
	integer                k;
	integer                m;
	integer                n;
	integer                p;

	// Decode helpers
	function is_shared;
		input [`ID_W-1:0] id;
		begin
			is_shared = (id >= `SHARED_FIRST) && (id <= `SHARED_LAST);
		end
	endfunction

	function is_soft;
		input [`ID_W-1:0] id;
		begin
			is_soft = (id <= `SOFT_LAST);
		end
	endfunction

	// Group to line: fast at top level, else fast unless group 1 matches the current security
	function route_fast;
		input [`GRP_W-1:0] grp;
		input              sec;
		input              top;
		begin
			if (top)
				route_fast = 1'b1;
			else if (grp == `GRP_SEC_G0)
				route_fast = 1'b1;
			else if (grp == `GRP_SEC_G1)
				route_fast = !sec;
			else
				route_fast = sec;
		end
	endfunction

	// All four affinity levels must agree
	function aff_match;
		input [`AFF_W-1:0] a;
		input [`AFF_W-1:0] b;
		begin
			aff_match = (a == b);
		end
	endfunction

	// Message level latches for shared sources
	always @* begin
		next_msg_level = shared_msg_level;
		for (j = 0; j < `NUM_SHARED; j = j + 1) begin
			if (shared_clear_wr && shared_msg_id == `SHARED_FIRST + j[`ID_W-1:0])
				next_msg_level[j] = 1'b0;
			if (shared_set_wr && shared_msg_id == `SHARED_FIRST + j[`ID_W-1:0])
				next_msg_level[j] = 1'b1;
		end
	end

	// Effective source lines; software sources are a one-cycle pulse
	always @* begin
		line = {`NUM_SRC{1'b0}};
		for (k = 0; k < `NUM_SOFT; k = k + 1)
			line[k] = soft_wr && is_soft(soft_id) && soft_id[3:0] == k[3:0];
		for (k = 0; k < `NUM_PRIV; k = k + 1)
			line[`NUM_SOFT + k] = private_irq_wire[k];
		for (k = 0; k < `NUM_SHARED; k = k + 1)
			line[`NUM_SOFT + `NUM_PRIV + k] = shared_irq_wire[k] | shared_msg_level[k];
	end

	// Deliverable requests and line selection
	always @* begin
		targeted = aff_match(shared_target_aff, core_affinity_id_reg);
		for (m = 0; m < `NUM_SRC; m = m + 1) begin
			req[m] = pend[m] && !act[m] && src_enable[m] && src_prio_ok[m];
			if (m >= `NUM_SOFT + `NUM_PRIV)
				req[m] = req[m] && targeted;
			fast_sel[m] = route_fast(src_group[m*`GRP_W +: `GRP_W], core_secure,
				core_top_level);
		end
	end

	// Lowest identifier wins the acknowledge
	always @* begin
		pick_ok = 1'b0;
		pick_id = `ID_NONE;
		for (n = `NUM_SRC - 1; n >= 0; n = n - 1) begin
			if (req[n]) begin
				pick_ok = 1'b1;
				pick_id = n[`ID_W-1:0];
			end
		end
	end

	// Lifecycle update, all sources in one cycle
	always @* begin
		next_pend = pend;
		next_act = act;
		ack_take = 1'b0;
		eoi_hit = 1'b0;
		for (i = 0; i < `NUM_SRC; i = i + 1) begin
			ack_take = ack_rd && pick_ok && pick_id == i[`ID_W-1:0];
			eoi_hit = eoi_wr && eoi_id == i[`ID_W-1:0];
			if (src_edge[i] || i < `NUM_SOFT) begin
				// Edge: pending cleared by acknowledge, new edge always wins
				if (ack_take)
					next_pend[i] = 1'b0;
				if (line[i] && !line_q[i])
					next_pend[i] = 1'b1;
				if (i < `NUM_SOFT && line[i])
					next_pend[i] = 1'b1;
				if (ack_take)
					next_act[i] = 1'b1;
				else if (eoi_hit)
					next_act[i] = 1'b0;
			end else begin
				// Level: pending mirrors the line, so it drops by itself
				next_pend[i] = line[i];
				if (ack_take)
					next_act[i] = 1'b1;
				else if (eoi_hit)
					next_act[i] = 1'b0;
			end
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			pend <= {`NUM_SRC{1'b0}};
			act <= {`NUM_SRC{1'b0}};
			line_q <= {`NUM_SRC{1'b0}};
			shared_msg_level <= {`NUM_SHARED{1'b0}};
		end else begin
			pend <= next_pend;
			act <= next_act;
			line_q <= line;
			shared_msg_level <= next_msg_level;
		end
	end

	// Registered outputs; request lines lag state by one cycle
	always @(posedge clk) begin
		if (!rst_n) begin
			irq_normal <= 1'b0;
			irq_fast <= 1'b0;
			ack_valid <= 1'b0;
			ack_id <= `ID_NONE;
			src_state <= {`NUM_SRC*2{1'b0}};
			loc_msg_valid <= 1'b0;
			loc_msg_id_out <= {`LOC_ID_W{1'b0}};
			top_affinity_level_support_flag <= 1'b0;
		end else begin
			irq_fast <= |(req & fast_sel);
			irq_normal <= |(req & ~fast_sel);
			ack_valid <= ack_rd;
			if (ack_rd)
				ack_id <= pick_id;
			for (p = 0; p < `NUM_SRC; p = p + 1)
				src_state[p*2 +: 2] <= {next_act[p], next_pend[p]};
			loc_msg_valid <= loc_msg_wr;
			if (loc_msg_wr)
				loc_msg_id_out <= loc_msg_id;
			top_affinity_level_support_flag <= `TOP_AFF_MULTI;
		end
	end

endmodule // interrupt_state_signaling
`default_nettype wire

/* File: verilog/irq_state_regs.vh */
// Purpose: Constants for the interrupt lifecycle block
// Assumes: One core, sources 0..63 implemented
// Notes:   Identifier widths and ranges
`ifndef IRQ_STATE_REGS_VH
`define IRQ_STATE_REGS_VH

`define NUM_SRC         64
`define ID_W            10
`define LOC_ID_W        16
`define SOFT_FIRST      10'h000
`define SOFT_LAST       10'h00f
`define PRIV_FIRST      10'h010
`define PRIV_LAST       10'h01f
`define SHARED_FIRST    10'h020
`define SHARED_LAST     10'h3fb
`define SHARED_IMPL_MAX 10'h03f
`define ID_NONE         10'h3ff
`define NUM_SOFT        16
`define NUM_PRIV        16
`define NUM_SHARED      32
`define GRP_W           2
`define GRP_SEC_G0      2'h0
`define GRP_SEC_G1      2'h1
`define GRP_NS_G1       2'h2
`define ST_INACTIVE     2'h0
`define ST_PENDING      2'h1
`define ST_ACTIVE       2'h2
`define ST_ACT_PEND     2'h3
`define AFF_W           32
`define TOP_AFF_MULTI   1'b1

`endif

/* File: testbench/periph_model.sv */
// Purpose: Peripheral side driving the shared wires
// Assumes: Bench sets the wanted levels
// Notes:   Flop stage keeps the update off the bench's drive edge
`default_nettype none
module periph_model (
	input  wire logic        clk,
	input  wire logic [31:0] want,
	output var  logic [31:0] line
);
	initial line = 32'h00000000;
	// Level held until the peripheral drops it
	always @(posedge clk) line <= want;
endmodule // periph_model
`default_nettype wire

/* File: testbench/irq_state_signaling_asserts.sv */
// Purpose: Port checks for the lifecycle block
// Assumes: Single clock domain
// Notes:   Level checks watch id 40 only
`default_nettype none
module irq_state_chk (
	input wire logic         clk, rst_n, ack_rd, eoi_wr, loc_msg_wr, core_top_level,
	input wire logic         irq_normal, ack_valid, loc_msg_valid,
	input wire logic         top_affinity_level_support_flag,
	input wire logic [31:0]  shared_irq_wire,
	input wire logic [9:0]   eoi_id, ack_id,
	input wire logic [15:0]  loc_msg_id, loc_msg_id_out,
	input wire logic [63:0]  src_edge,
	input wire logic [127:0] src_state
);
	wire [1:0] e_st = src_state[{eoi_id[5:0], 1'b0} +: 2];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_ACK_VALID: assert property (ack_rd |=> ack_valid)
		else $error("ack without answer");
	AST_ACK_ONLY: assert property (!$past(ack_rd) |-> !ack_valid)
		else $error("answer without ack");
	AST_ACK_ACTIVE: assert property (ack_valid && ack_id < 10'h040
		|-> src_state[{ack_id[5:0], 1'b1}])
		else $error("acked source not active");
	AST_FLAG: assert property ($past(rst_n) |-> top_affinity_level_support_flag)
		else $error("affinity flag low");
	AST_LOC_MSG: assert property (loc_msg_wr |=> loc_msg_valid
		&& loc_msg_id_out == $past(loc_msg_id))
		else $error("message not passed");
	AST_LVL_PEND: assert property (!src_edge[40] && shared_irq_wire[8]
		&& src_state[81:80] == 2'h0 |=> src_state[80])
		else $error("level source not pending");
	AST_EDGE_EOI: assert property (eoi_wr && eoi_id < 10'h040 && src_edge[eoi_id[5:0]]
		&& e_st == 2'h3 && !ack_rd ##1 $stable(eoi_id) |-> e_st == 2'h1)
		else $error("end of interrupt state wrong");
	AST_TOP_FAST: assert property ($past(core_top_level) |-> !irq_normal)
		else $error("normal line at top level");
endmodule // irq_state_chk
bind interrupt_state_signaling irq_state_chk i_chk (.clk(clk), .rst_n(rst_n),
	.ack_rd(ack_rd), .eoi_wr(eoi_wr), .loc_msg_wr(loc_msg_wr), .core_top_level(core_top_level),
	.irq_normal(irq_normal), .ack_valid(ack_valid), .loc_msg_valid(loc_msg_valid),
	.top_affinity_level_support_flag(top_affinity_level_support_flag),
	.shared_irq_wire(shared_irq_wire), .eoi_id(eoi_id), .ack_id(ack_id),
	.loc_msg_id(loc_msg_id), .loc_msg_id_out(loc_msg_id_out), .src_edge(src_edge),
	.src_state(src_state));
`default_nettype wire

/* File: testbench/interrupt_state_signaling_tb.sv */
// Purpose: Self-checking bench for the lifecycle block
// Assumes: Group 0 by default, prio always fits
// Notes:   Edge id random, level id fixed at 40
`default_nettype none
`include "irq_state_regs.vh"
module interrupt_state_signaling_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, set_wr = 0, clr_wr = 0, loc_wr = 0, ack = 0, eoi = 0;
	logic sec = 0, top = 0;
	logic [9:0] mid = 0, eid = 0;
	logic [15:0] lid = 0;
	logic [31:0] want = 0, tgt = 32'h00010203;
	logic [63:0] edg = 0, en = '1;
	logic [127:0] grp = 0;
	wire irqn, irqf, av, lv, flag;
	wire [9:0] aid;
	wire [15:0] lido;
	wire [31:0] line;
	wire [127:0] st;
	int n_errors = 0, n_checks = 0, cyc = 0, id, g, s, t;
	periph_model i_per (.clk(clk), .want(want), .line(line));
	interrupt_state_signaling i_dut (.clk(clk), .rst_n(rst_n), .shared_irq_wire(line),
		.private_irq_wire(16'h0000), .shared_set_wr(set_wr), .shared_clear_wr(clr_wr),
		.shared_msg_id(mid), .loc_msg_wr(loc_wr), .loc_msg_id(lid), .soft_wr(1'b0),
		.soft_id(10'h000), .src_enable(en), .src_edge(edg), .src_prio_ok({64{1'b1}}),
		.src_group(grp), .shared_target_aff(tgt), .core_affinity_id_reg(32'h00010203),
		.core_secure(sec), .core_top_level(top), .ack_rd(ack), .eoi_wr(eoi), .eoi_id(eid),
		.irq_normal(irqn), .irq_fast(irqf), .ack_valid(av), .ack_id(aid), .src_state(st),
		.loc_msg_valid(lv), .loc_msg_id_out(lido), .top_affinity_level_support_flag(flag));
	initial forever #2.5 clk = ~clk;
	task results;
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Expected {normal, fast} from group and core state
	function logic [1:0] lines(input logic [1:0] gr, input logic sc, input logic tp);
		if (gr == `GRP_SEC_G0 || tp)
			return 2'b01;
		return ((gr == `GRP_NS_G1) != sc) ? 2'b10 : 2'b01;
	endfunction
	always @(posedge clk) if (++cyc > 3000) begin
		n_errors++;
		results;
	end
	initial begin
		void'($urandom(67573));
		tick(5);
		rst_n = 1;
		tick(2);
		chk(flag, 1);
		want[8] = 1;
		tick(2);
		chk(st[81:80], `ST_PENDING);
		for (g = 0; g < 3; g++) for (s = 0; s < 2; s++) for (t = 0; t < 2; t++) begin
			grp[81:80] = g;
			sec = s;
			top = t;
			tick(2);
			chk({irqn, irqf}, lines(g, s, t));
		end
		ack = 1;
		tick(1);
		ack = 0;
		chk(av, 1);
		chk(aid, 40);
		chk(st[81:80], `ST_ACT_PEND);
		tick(1);
		chk({irqn, irqf}, 0);
		want[8] = 0;
		tick(2);
		chk(st[81:80], `ST_ACTIVE);
		eoi = 1;
		eid = 40;
		tick(1);
		eoi = 0;
		chk(st[81:80], `ST_INACTIVE);
		id = 48 + $urandom_range(15);
		edg[id] = 1;
		mid = id;
		set_wr = 1;
		tick(1);
		set_wr = 0;
		// Message latch feeds the line one edge later
		tick(1);
		chk(st[2*id+:2], `ST_PENDING);
		tick(1);
		ack = 1;
		tick(1);
		ack = 0;
		chk(aid, id);
		chk(st[2*id+:2], `ST_ACTIVE);
		// Drop the line first so the next set is a fresh edge
		clr_wr = 1;
		tick(1);
		clr_wr = 0;
		set_wr = 1;
		tick(1);
		set_wr = 0;
		tick(1);
		chk(st[2*id+:2], `ST_ACT_PEND);
		eoi = 1;
		eid = id;
		tick(1);
		eoi = 0;
		chk(st[2*id+:2], `ST_PENDING);
		tick(1);
		chk(irqf, 1);
		mid = 32;
		clr_wr = 1;
		tick(1);
		clr_wr = 0;
		chk(st[2*id+:2], `ST_PENDING);
		set_wr = 1;
		tgt = ~tgt;
		tick(1);
		set_wr = 0;
		ack = 1;
		tick(1);
		ack = 0;
		chk(aid, `ID_NONE);
		clr_wr = 1;
		tick(1);
		clr_wr = 0;
		tick(1);
		chk(st[65:64], `ST_INACTIVE);
		loc_wr = 1;
		lid = $urandom;
		tick(1);
		loc_wr = 0;
		chk(lv, 1);
		chk(lido, lid);
		chk(st[65:64], `ST_INACTIVE);
		results;
	end
endmodule // interrupt_state_signaling_tb
`default_nettype wire
